// ### core/adc_sar_control.sv
`timescale 1ns/10ps
// How it works
// - successive approximation gives 8-bit stored result
// - completion interrupt, can wake core from sleep
// - channel select steers the analog multiplexer
// - reference select routes supply, external or fixed
// - negative reference is always ground, unselectable
// - 3-bit clock select: six dividers or rc
// - one bit per period 1..8, ten periods per conversion
// - divided sources track system clock; rc independent
// - rc bit period lies between 1.0 and 6.0 us
// - go bit starts conversion, hardware clears it
// - completion clears go, sets flag, loads result
// - early go clear stores partial, fills last bit
// - sleep with divided clock aborts, powers off
module adc_sar_control (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic converter_enable_i, // software enable bit
  input wire logic go_set_i, // software writes one to go
  input wire logic go_clear_i, // software writes zero to go
  input wire logic [3:0] channel_select_i,
  input wire logic [1:0] reference_select_i,
  input wire logic [2:0] conversion_clock_select_i,
  input wire logic interrupt_enable_i,
  input wire logic done_flag_clear_i, // software clears the done flag
  input wire logic sleep_i, // core is in sleep
  input wire logic rc_clk_i, // dedicated rc oscillator, asynchronous
  input wire logic comparator_i, // analog comparator, asynchronous
  output logic go_o,
  output logic [7:0] conversion_result_o,
  output logic conversion_done_flag_o,
  output logic interrupt_request_o,
  output logic wake_o,
  output logic [3:0] mux_select_o,
  output logic [2:0] reference_route_o,
  output logic sample_hold_o, // high while the input is held
  output logic [7:0] dac_code_o, // trial code for the comparator
  output logic converter_powered_o,
  output logic rc_period_fault_o
);

  typedef enum logic [1:0] {
    IDLE = 2'b01,
    CONVERT = 2'b10
  } conv_state_e;

  // first decision period, local copy so the functions below can see it
  localparam logic [3:0] FIRST_BIT_PERIOD_L = adc_sar_pkg::FIRST_BIT_PERIOD;

  ////////////////////////////////////////////////////////////////////////////
  // functions

  // divider ratio minus one for a system-clock source
  function automatic logic [5:0] div_last(input logic [2:0] sel);
    logic [5:0] base;
    base = 6'h01;
    case (sel[1:0])
      2'h0: base = 6'h01;
      2'h1: base = 6'h07;
      2'h2: base = 6'h1F;
      default: base = 6'h01;
    endcase
    // bit 2 doubles the ratio (2->4, 8->16, 32->64)
    div_last = sel[2] ? 6'({base, 1'b1}) : base;
  endfunction : div_last

  // early-terminated result: unconverted bits copy the last decided bit
  function automatic logic [7:0] partial_fill(input logic [7:0] sar, input logic [3:0] period,
                                              input logic last);
    logic [7:0] res;
    res = 8'h00;
    for (int i = 0; i < 8; i++) begin
      // bit i was decided when period > 8 - i
      if (period > 4'(8 - i)) begin
        res[i] = sar[i];
      end else if (period > FIRST_BIT_PERIOD_L) begin
        res[i] = last;
      end
    end
    partial_fill = res;
  endfunction : partial_fill

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers

  logic [2:0] rc_sync_q; // rc clock, three stages
  logic [2:0] cmp_sync_q; // comparator, three stages
  logic rc_level_q; // filtered rc level
  logic cmp_level_q; // filtered comparator level

  // stage 0 feeds only stage 1; a level counts once stages 1 and 2 agree
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rc_sync_q <= 3'h0;
      cmp_sync_q <= 3'h0;
      rc_level_q <= 1'b0;
      cmp_level_q <= 1'b0;
    end else begin
      rc_sync_q <= {rc_sync_q[1:0], rc_clk_i};
      cmp_sync_q <= {cmp_sync_q[1:0], comparator_i};
      if (rc_sync_q[1] == rc_sync_q[2]) begin
        rc_level_q <= rc_sync_q[2];
      end
      if (cmp_sync_q[1] == cmp_sync_q[2]) begin
        cmp_level_q <= cmp_sync_q[2];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // conversion clock

  conv_state_e state_q;
  logic [5:0] div_cnt_q; // system clock divider
  logic rc_prev_q;
  logic rc_edge; // one cycle per rc rising edge
  logic rc_selected;
  logic tick; // end of one bit period
  logic start; // conversion begins this cycle
  logic sleep_abort;
  logic early_stop;
  logic [3:0] period_q; // bit period in progress, 0..9
  logic finish; // last bit period ends

  assign rc_selected = conversion_clock_select_i[1:0] == adc_sar_pkg::CLKSEL_RC_LOW;
  assign rc_edge = rc_level_q && !rc_prev_q;
  // divided sources count system clocks, so they track its rate; rc does not
  assign tick = (state_q == CONVERT) &&
                (rc_selected ? rc_edge
                             : div_cnt_q == div_last(conversion_clock_select_i));

  // divider restarts at start so the first bit period is full length
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      div_cnt_q <= 6'h00;
      rc_prev_q <= 1'b0;
    end else begin
      rc_prev_q <= rc_level_q;
      if (start || state_q != CONVERT || tick) begin
        div_cnt_q <= 6'h00;
      end else begin
        div_cnt_q <= div_cnt_q + 6'h01;
      end
    end
  end

  // rc period monitor: rc edges spaced outside the legal bit-period window
  logic [9:0] rc_gap_q;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rc_gap_q <= 10'h000;
      rc_period_fault_o <= 1'b0;
    end else if (!(rc_selected && state_q == CONVERT)) begin
      rc_gap_q <= 10'h000;
    end else if (rc_edge) begin
      rc_gap_q <= 10'h000;
      // first edge after start has no reference point
      if (period_q != 4'h0 && rc_gap_q < adc_sar_pkg::RC_MIN_CYCLES) begin
        rc_period_fault_o <= 1'b1;
      end
    end else if (rc_gap_q == adc_sar_pkg::RC_MAX_CYCLES) begin
      rc_period_fault_o <= 1'b1;
    end else begin
      rc_gap_q <= rc_gap_q + 10'h001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencing

  logic power_off_q; // converter shut by sleep, enable bit untouched
  logic [7:0] sar_q; // decided bits plus current trial bit
  logic last_bit_q; // most recently decided bit
  logic keep_bit;
  logic [7:0] trial_mask;
  logic [7:0] final_result;

  assign start = go_set_i && converter_enable_i && !power_off_q && state_q == IDLE;
  // sleep stops a conversion clocked from the system clock
  assign sleep_abort = sleep_i && !rc_selected && state_q == CONVERT;
  assign finish = tick && period_q == adc_sar_pkg::BIT_PERIODS_PER_CONVERSION - 4'h1;
  assign early_stop = go_clear_i && state_q == CONVERT && !finish && !sleep_abort;
  assign keep_bit = cmp_level_q; // comparator high: input at or above trial
  assign trial_mask = 8'h80 >> (period_q - FIRST_BIT_PERIOD_L);
  assign final_result = sar_q;

  // state and bit-period counter
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_q <= IDLE;
      period_q <= 4'h0;
    end else begin
      case (state_q)
        IDLE: begin
          period_q <= 4'h0;
          if (start) begin
            state_q <= CONVERT;
          end
        end
        CONVERT: begin
          if (finish || early_stop || sleep_abort || !converter_enable_i) begin
            state_q <= IDLE;
          end else if (tick) begin
            period_q <= period_q + 4'h1;
          end
        end
        default: state_q <= IDLE;
      endcase
    end
  end

  // approximation register: one bit decided per bit period 1..8
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sar_q <= adc_sar_pkg::RESULT_RESET;
      last_bit_q <= 1'b0;
    end else if (start) begin
      sar_q <= 8'h00;
    end else if (tick && period_q == 4'h0) begin
      sar_q <= adc_sar_pkg::FIRST_TRIAL_CODE;
    end else if (tick && period_q >= FIRST_BIT_PERIOD_L &&
                 period_q <= adc_sar_pkg::LAST_BIT_PERIOD) begin
      last_bit_q <= keep_bit;
      // drop the trial bit if too high, then try the next lower one
      sar_q <= (keep_bit ? sar_q : (sar_q & ~trial_mask)) | (trial_mask >> 1);
    end
  end

  // go bit: hardware clears at the end, software may clear early
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      go_o <= 1'b0;
    end else if (start) begin
      go_o <= 1'b1;
    end else if (finish || go_clear_i || sleep_abort || !converter_enable_i) begin
      go_o <= 1'b0;
    end
  end

  // result register
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      conversion_result_o <= adc_sar_pkg::RESULT_RESET;
    end else if (finish && !sleep_abort) begin
      conversion_result_o <= final_result;
    end else if (early_stop) begin
      conversion_result_o <= partial_fill(sar_q, period_q, last_bit_q);
    end
  end

  // done flag: a completion in the clearing cycle wins
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      conversion_done_flag_o <= 1'b0;
    end else if (finish && !sleep_abort) begin
      conversion_done_flag_o <= 1'b1;
    end else if (done_flag_clear_i) begin
      conversion_done_flag_o <= 1'b0;
    end
  end

  // power-off under sleep; cleared on wake
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      power_off_q <= 1'b0;
    end else if (!sleep_i) begin
      power_off_q <= 1'b0;
    end else if (sleep_abort) begin
      power_off_q <= 1'b1;
    end else if (finish && !interrupt_enable_i) begin
      power_off_q <= 1'b1; // sleep conversion done with no wake
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // analog-side controls

  // mux and reference registered so the analog switches change cleanly;
  // the acquisition wait after a channel change is software's job
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mux_select_o <= adc_sar_pkg::CHANNEL_RESET;
      reference_route_o <= adc_sar_pkg::REF_ROUTE_SUPPLY;
      sample_hold_o <= 1'b0;
      dac_code_o <= 8'h00;
    end else begin
      mux_select_o <= channel_select_i;
      // negative reference is hard-wired to ground, nothing to route
      case (reference_select_i)
        adc_sar_pkg::REFSEL_EXTERNAL: reference_route_o <= adc_sar_pkg::REF_ROUTE_EXTERNAL;
        adc_sar_pkg::REFSEL_FIXED: reference_route_o <= adc_sar_pkg::REF_ROUTE_FIXED;
        default: reference_route_o <= adc_sar_pkg::REF_ROUTE_SUPPLY;
      endcase
      sample_hold_o <= state_q == CONVERT && !finish && !early_stop && !sleep_abort;
      dac_code_o <= sar_q;
    end
  end

  assign converter_powered_o = converter_enable_i && !power_off_q;
  assign interrupt_request_o = conversion_done_flag_o && interrupt_enable_i;
  assign wake_o = interrupt_request_o && sleep_i;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  logic [4:0] tick_count_q; // bit periods seen in this conversion
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tick_count_q <= 5'h00;
    end else if (start) begin
      tick_count_q <= 5'h00;
    end else if (tick && tick_count_q != 5'h1F) begin
      tick_count_q <= tick_count_q + 5'h01;
    end
  end

  sequence s_completion;
    finish && !sleep_abort;
  endsequence

  sequence s_flag_then_irq;
    conversion_done_flag_o ##0 (interrupt_request_o == interrupt_enable_i);
  endsequence

  chk_ten_periods: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    s_completion |-> tick_count_q == 5'h09) else $error("conversion not ten bit periods");
  chk_done_sets_flag: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    s_completion |=> s_flag_then_irq and !go_o) else $error("completion effects missing");
  chk_result_loaded: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    s_completion |=> conversion_result_o == $past(sar_q)) else $error("result not loaded");
  chk_partial_fill: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    early_stop && period_q == 4'h4 |=>
      conversion_result_o[4:0] == {5{$past(last_bit_q)}}) else $error("partial fill wrong");
  chk_divider_restart: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    start |=> div_cnt_q == 6'h00 ##1 div_cnt_q == 6'h01) else $error("divider not restarted");
  chk_div2_spacing: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    tick && !finish && !early_stop && conversion_clock_select_i == adc_sar_pkg::CLKSEL_DIV2
      && $stable(conversion_clock_select_i) |=> !tick ##1 tick) else $error("div2 spacing");
  chk_sleep_abort: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    sleep_abort |=> state_q == IDLE && !go_o && !converter_powered_o
      ) else $error("sleep did not abort");
  chk_go_start: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    start |=> go_o && state_q == CONVERT) else $error("go did not start conversion");
  chk_mux_follow: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    $changed(channel_select_i) |=> mux_select_o == $past(channel_select_i)
      ) else $error("mux not following select");
  chk_ref_fixed: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    reference_select_i == adc_sar_pkg::REFSEL_FIXED |=>
      reference_route_o == adc_sar_pkg::REF_ROUTE_FIXED) else $error("reference route wrong");

endmodule : adc_sar_control

// ### common/adc_sar_pkg.sv
package adc_sar_pkg;

  // conversion clock select codes (3-bit field)
  localparam logic [2:0] CLKSEL_DIV2 = 3'h0;
  localparam logic [2:0] CLKSEL_DIV4 = 3'h4;
  localparam logic [2:0] CLKSEL_DIV8 = 3'h1;
  localparam logic [2:0] CLKSEL_DIV16 = 3'h5;
  localparam logic [2:0] CLKSEL_DIV32 = 3'h2;
  localparam logic [2:0] CLKSEL_DIV64 = 3'h6;
  // low two bits both set selects the dedicated rc clock, bit 2 ignored
  localparam logic [1:0] CLKSEL_RC_LOW = 2'h3;

  // reference select codes (2-bit field); 0x picks the supply
  localparam logic [1:0] REFSEL_EXTERNAL = 2'h2;
  localparam logic [1:0] REFSEL_FIXED = 2'h3;
  // routed positive reference, one-hot toward the analog switch
  localparam logic [2:0] REF_ROUTE_SUPPLY = 3'h1;
  localparam logic [2:0] REF_ROUTE_EXTERNAL = 3'h2;
  localparam logic [2:0] REF_ROUTE_FIXED = 3'h4;

  // bit-period sequencing
  localparam int RESULT_WIDTH = 8;
  localparam logic [3:0] BIT_PERIODS_PER_CONVERSION = 4'hA;
  localparam logic [3:0] FIRST_BIT_PERIOD = 4'h1;
  localparam logic [3:0] LAST_BIT_PERIOD = 4'h8;
  localparam logic [7:0] FIRST_TRIAL_CODE = 8'h80;

  // reset values
  localparam logic [7:0] RESULT_RESET = 8'h00;
  localparam logic [3:0] CHANNEL_RESET = 4'h0;

  // timing: system clock and rc bit-period window
  localparam int CLK_PERIOD_NS = 10;
  localparam int RC_BIT_PERIOD_MIN_NS = 1000;
  localparam int RC_BIT_PERIOD_TYP_NS = 1600;
  localparam int RC_BIT_PERIOD_MAX_NS = 6000;
  localparam logic [9:0] RC_MIN_CYCLES =
    10'((RC_BIT_PERIOD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [9:0] RC_MAX_CYCLES = 10'(RC_BIT_PERIOD_MAX_NS / CLK_PERIOD_NS);

endpackage : adc_sar_pkg

// ### test/analog_front_model.sv
`timescale 1ns/10ps
// analog pins, reference sources and rc oscillator facing the converter
module analog_front_model #(
  parameter int SUPPLY_MV = 3300,
  parameter int EXTERNAL_MV = 2048,
  parameter int FIXED_MV = 1024
) (
  input wire logic clk_i,
  input wire logic [3:0] mux_select_i,
  input wire logic [2:0] reference_route_i,
  input wire logic sample_hold_i,
  input wire logic [7:0] dac_code_i,
  input wire logic rc_run_i, // oscillator gate
  input wire logic [31:0] rc_half_i, // half period in system cycles
  input wire logic [11:0] level_mv_i [16], // pin voltage per channel
  output logic comparator_o,
  output logic rc_clk_o
);
  int ref_mv; // positive reference in millivolts
  int v; // scaled level before clipping
  logic [7:0] held_q = 8'h00; // sample and hold capacitor
  logic noise_q = 1'b0; // output while nothing is held
  ////////////////////////////////////////////////////////////////
  // positive reference from the one-hot route
  always_comb begin
    ref_mv = reference_route_i[2] ? FIXED_MV : (reference_route_i[1] ? EXTERNAL_MV : SUPPLY_MV);
  end
  // one pin onto the single hold stage; negative side is ground
  always @(posedge sample_hold_i) begin
    v = int'(level_mv_i[mux_select_i]) * 256 / ref_mv;
    held_q = (v > 255) ? 8'hFF : 8'(v);
  end
  // no held sample means no meaningful answer, so toggle
  always @(posedge clk_i) noise_q <= ~noise_q;
  assign comparator_o = sample_hold_i ? (held_q >= dac_code_i) : noise_q;
  // rc oscillator stands low while gated off, odd phase at start
  initial rc_clk_o = 1'b0;
  always begin
    if (rc_run_i) begin
      #(rc_half_i * 10) rc_clk_o = ~rc_clk_o;
    end else begin
      rc_clk_o = 1'b0;
      @(rc_run_i);
      #3;
    end
  end
endmodule : analog_front_model

// ### test/tb.sv
`timescale 1ns/10ps
// self-checking bench for the converter control block
module tb;
  logic clk_i = 1'b0; // 100 MHz system clock
  logic reset_n_i = 1'b0;
  logic converter_enable_i = 1'b0;
  logic go_set_i = 1'b0;
  logic go_clear_i = 1'b0;
  logic [3:0] channel_select_i = 4'h0;
  logic [1:0] reference_select_i = 2'h0;
  logic [2:0] conversion_clock_select_i = 3'h6;
  logic interrupt_enable_i = 1'b0;
  logic done_flag_clear_i = 1'b0;
  logic sleep_i = 1'b0;
  logic rc_clk_i;
  logic comparator_i;
  logic go_o;
  logic [7:0] conversion_result_o;
  logic conversion_done_flag_o;
  logic interrupt_request_o;
  logic wake_o;
  logic [3:0] mux_select_o;
  logic [2:0] reference_route_o;
  logic sample_hold_o;
  logic [7:0] dac_code_o;
  logic converter_powered_o;
  logic rc_period_fault_o;
  logic rc_run = 1'b0; // far-side oscillator gate
  int rc_half = 80; // 1.6 us bit period
  logic [11:0] level_mv [16]; // pin voltages
  int miscompares = 0;
  int checks = 0;
  int cyc = 0;
  int t_go = 0; // cycle at which busy rose
  logic go_prev = 1'b0;
  int q_res[$]; // expected result, negative when not judged
  int q_flag[$]; // expected flag, negative when not judged
  int q_lo[$]; // shortest busy span
  int q_hi[$]; // longest busy span
  int code;
  int ch;
  int divs [6] = '{2, 4, 8, 16, 32, 64};
  logic [2:0] sels [6] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6};
  ////////////////////////////////////////////////////////////////
  always #5 clk_i = ~clk_i;
  adc_sar_control uut (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .converter_enable_i(converter_enable_i), .go_set_i(go_set_i), .go_clear_i(go_clear_i),
    .channel_select_i(channel_select_i), .reference_select_i(reference_select_i),
    .conversion_clock_select_i(conversion_clock_select_i),
    .interrupt_enable_i(interrupt_enable_i), .done_flag_clear_i(done_flag_clear_i),
    .sleep_i(sleep_i), .rc_clk_i(rc_clk_i), .comparator_i(comparator_i), .go_o(go_o),
    .conversion_result_o(conversion_result_o), .conversion_done_flag_o(conversion_done_flag_o),
    .interrupt_request_o(interrupt_request_o), .wake_o(wake_o), .mux_select_o(mux_select_o),
    .reference_route_o(reference_route_o), .sample_hold_o(sample_hold_o),
    .dac_code_o(dac_code_o), .converter_powered_o(converter_powered_o),
    .rc_period_fault_o(rc_period_fault_o));
  analog_front_model far (.clk_i(clk_i), .mux_select_i(mux_select_o),
    .reference_route_i(reference_route_o), .sample_hold_i(sample_hold_o),
    .dac_code_i(dac_code_o), .rc_run_i(rc_run), .rc_half_i(rc_half),
    .level_mv_i(level_mv), .comparator_o(comparator_i), .rc_clk_o(rc_clk_i));
  ////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %0h seen %0h", what, exp, got);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask : tick
  // one-cycle write of one to the go bit
  task automatic start();
    @(posedge clk_i) go_set_i <= 1'b1;
    @(posedge clk_i) go_set_i <= 1'b0;
  endtask : start
  task automatic expect_done(input int res, input int flag, input int lo, input int hi);
    q_res.push_back(res);
    q_flag.push_back(flag);
    q_lo.push_back(lo);
    q_hi.push_back(hi);
  endtask : expect_done
  // bounded wait for busy to drop
  task automatic wait_idle();
    int n;
    n = 0;
    @(posedge clk_i);
    while (go_o !== 1'b0 && n < 20000) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 20000) begin
      miscompares++;
      stop_test();
    end else begin
      tick(2);
    end
  endtask : wait_idle
  // ideal code for a level against the chosen reference
  function automatic int code_of(input int mv, input logic [1:0] rs);
    int r;
    r = rs[1] ? (rs[0] ? 1024 : 2048) : 3300;
    return (mv * 256 / r > 255) ? 255 : mv * 256 / r;
  endfunction : code_of
  task automatic stop_test();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : stop_test
  ////////////////////////////////////////////////////////////////
  // watcher: each busy fall takes the oldest note
  always @(posedge clk_i) begin : watch
    int d;
    cyc++;
    if (go_o === 1'b1 && go_prev !== 1'b1) t_go = cyc;
    if (go_o === 1'b0 && go_prev === 1'b1 && q_res.size() > 0) begin
      d = cyc - t_go;
      if (q_res[0] >= 0) check("result", 16'(q_res[0]), {8'h00, conversion_result_o});
      if (q_flag[0] >= 0) check("flag", 16'(q_flag[0]), {15'h0, conversion_done_flag_o});
      check("span", 16'(q_lo[0]), 16'((d < q_lo[0] || d > q_hi[0]) ? d : q_lo[0]));
      void'(q_res.pop_front());
      void'(q_flag.pop_front());
      void'(q_lo.pop_front());
      void'(q_hi.pop_front());
    end
    go_prev = go_o;
  end
  // hang guard at 40000 cycles, well beyond the roughly 6000 the run needs
  initial begin : watchdog
    #400000;
    miscompares++;
    stop_test();
  end
  ////////////////////////////////////////////////////////////////
  // main sequence
  initial begin : main
    void'($urandom(54));
    for (int i = 0; i < 16; i++) level_mv[i] = 12'($urandom_range(3300, 0));
    level_mv[0] = 12'h000; // grounded pin gives code zero
    repeat (2) @(posedge clk_i);
    reset_n_i <= 1'b1;
    converter_enable_i <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_i) reference_select_i <= 2'(i);
      channel_select_i <= 4'($urandom_range(15, 0));
      tick(2);
      check("route", {13'h0, i[1] ? (i[0] ? 3'h4 : 3'h2) : 3'h1}, {13'h0, reference_route_o});
      check("mux", {12'h0, channel_select_i}, {12'h0, mux_select_o});
    end
    $display("test routing done");
    // every divider, random idle phase before each start
    for (int i = 0; i < 6; i++) begin
      @(posedge clk_i) conversion_clock_select_i <= sels[i];
      done_flag_clear_i <= 1'b1;
      @(posedge clk_i) done_flag_clear_i <= 1'b0;
      tick($urandom_range(7, 0));
      expect_done(-1, 1, 10 * divs[i], 10 * divs[i]);
      start();
      wait_idle();
    end
    $display("test dividers done");
    // full conversion at the slowest divider, second start ignored
    ch = $urandom_range(13, 1);
    @(posedge clk_i) channel_select_i <= 4'(ch);
    reference_select_i <= 2'h0;
    interrupt_enable_i <= 1'b1;
    tick(20);
    expect_done(code_of(level_mv[ch], 2'h0), 1, 640, 640);
    start();
    tick(200);
    start();
    wait_idle();
    check("irq", 16'h0001, {15'h0, interrupt_request_o});
    @(posedge clk_i) sleep_i <= 1'b1;
    tick(2);
    check("wake", 16'h0001, {15'h0, wake_o});
    @(posedge clk_i) sleep_i <= 1'b0;
    interrupt_enable_i <= 1'b0;
    tick(2);
    check("irq off", 16'h0000, {15'h0, interrupt_request_o});
    $display("test conversion done");
    // early stop in period four: three bits decided
    ch = $urandom_range(13, 1);
    @(posedge clk_i) channel_select_i <= 4'(ch);
    done_flag_clear_i <= 1'b1;
    @(posedge clk_i) done_flag_clear_i <= 1'b0;
    tick(20);
    code = code_of(level_mv[ch], 2'h0);
    code = (code & 8'hE0) | (code[5] ? 8'h1F : 8'h00);
    expect_done(code, -1, 0, 700);
    start();
    tick(287);
    @(posedge clk_i) go_clear_i <= 1'b1;
    @(posedge clk_i) go_clear_i <= 1'b0;
    wait_idle();
    $display("test early stop done");
    // sleep with a divided clock aborts and powers down
    @(posedge clk_i) done_flag_clear_i <= 1'b1;
    @(posedge clk_i) done_flag_clear_i <= 1'b0;
    expect_done(code, 0, 0, 700);
    start();
    tick(100);
    @(posedge clk_i) sleep_i <= 1'b1;
    wait_idle();
    check("powered", 16'h0000, {15'h0, converter_powered_o});
    start();
    tick(3);
    check("go", 16'h0000, {15'h0, go_o});
    @(posedge clk_i) sleep_i <= 1'b0;
    tick(2);
    check("powered", 16'h0001, {15'h0, converter_powered_o});
    $display("test sleep done");
    // both rc encodings, oscillator gated around each run
    for (int i = 0; i < 2; i++) begin
      @(posedge clk_i) conversion_clock_select_i <= i[0] ? 3'h7 : 3'h3;
      channel_select_i <= i[0] ? 4'hF : 4'h0;
      done_flag_clear_i <= 1'b1;
      rc_run <= 1'b1;
      @(posedge clk_i) done_flag_clear_i <= 1'b0;
      tick(20);
      expect_done(code_of(level_mv[i[0] ? 15 : 0], 2'h0), 1, 1440, 1620);
      start();
      wait_idle();
      @(posedge clk_i) rc_run <= 1'b0;
      check("rc fault", 16'h0000, {15'h0, rc_period_fault_o});
    end
    $display("test rc clock done");
    stop_test();
  end
endmodule : tb
